// *** drvsc_pkg.sv ***
/*
  Constants, object indices and carrier types for the drive mode select
  and position scaling block. Assumes a CANopen object dictionary front end
  that turns SDO traffic into single-cycle object requests.
*/
package drvsc_pkg;
  // Mode codes, shared by selector and display
  localparam logic [7:0] MODE_OFF = 8'h00;
  localparam logic [7:0] MODE_PP = 8'h01;
  localparam logic [7:0] MODE_PV = 8'h03;
  localparam logic [7:0] MODE_HOME = 8'h06;
  localparam logic [7:0] MODE_CSP = 8'h08;
  // Object indices and subindices
  localparam logic [15:0] OD_MODE_SEL = 16'h6060;
  localparam logic [15:0] OD_MODE_DISP = 16'h6061;
  localparam logic [15:0] OD_WINDOW = 16'h6067;
  localparam logic [15:0] OD_HOME_OFF = 16'h607C;
  localparam logic [15:0] OD_LIMIT = 16'h607D;
  localparam logic [15:0] OD_POLARITY = 16'h607E;
  localparam logic [15:0] OD_ENC_RES = 16'h608F;
  localparam logic [15:0] OD_GEAR = 16'h6091;
  localparam logic [15:0] OD_FEED = 16'h6092;
  localparam logic [15:0] OD_FACTOR = 16'h6093;
  localparam logic [7:0] SUB_0 = 8'h00;
  localparam logic [7:0] SUB_1 = 8'h01;
  localparam logic [7:0] SUB_2 = 8'h02;
  localparam logic [31:0] OD_ENTRIES = 32'h0000_0002;
  // Bit positions
  localparam int CW_NEW_SP = 4;
  localparam int POL_POS_BIT = 7;
  localparam int POL_SPD_BIT = 6;
  localparam int ERR_CONV_BIT = 11;
  // Abort and emergency codes
  localparam logic [31:0] ABT_FACTOR = 32'h0604_0047;
  localparam logic [31:0] ABT_READ_ONLY = 32'h0601_0002;
  localparam logic [31:0] ABT_NO_OBJ = 32'h0602_0000;
  localparam logic [31:0] ABT_RANGE = 32'h0609_0030;
  localparam logic [15:0] EMCY_CONV = 16'hFF01;
  localparam logic [15:0] EMCY_CLEAR = 16'h0000;
  // Reset values
  localparam logic [7:0] RST_MODE = 8'h01;
  localparam logic [7:0] RST_POL = 8'h00;
  localparam logic [31:0] RST_ONE = 32'h0000_0001;
  localparam logic [31:0] RST_LIM_MIN = 32'h94B6_2E00;
  localparam logic [31:0] RST_LIM_MAX = 32'h6B49_D200;
  localparam logic [31:0] RST_WINDOW = 32'h0000_0020;
  localparam logic [31:0] RST_HOME_OFF = 32'h0000_0000;
  // Standard resolutions per controller variant
  localparam logic [31:0] INC_BRUSHLESS = 32'h0000_0BB8;
  localparam logic [31:0] INC_BRUSHED = 32'h0000_0800;
  localparam logic [31:0] INC_ABSOLUTE = 32'h0000_1000;
  // Scaling limits
  localparam logic [95:0] FAC_NUM_LIMIT = 96'h7735_9400;
  localparam logic signed [63:0] POS_MAX = 64'sh0000_0000_7FFF_FFFF;
  localparam logic signed [63:0] POS_MIN = 64'shFFFF_FFFF_8000_0000;

  typedef enum logic [1:0] {
    DRVSC_RUN = 2'b00,
    DRVSC_WAIT_SP = 2'b01,
    DRVSC_WAIT_EDGE = 2'b10
  } drvsc_mst_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [15:0] index;
    logic [7:0] sub;
    logic [31:0] data;
  } drvsc_od_req_t;

  typedef struct packed {
    logic valid;
    logic abort;
    logic [31:0] data;
  } drvsc_od_rsp_t;

  typedef struct packed {
    logic valid;
    logic to_user;
    logic [31:0] value;
  } drvsc_conv_req_t;

  typedef struct packed {
    logic valid;
    logic ovf;
    logic [31:0] value;
  } drvsc_conv_rsp_t;

  typedef struct packed {
    drvsc_mst_t mst;
    logic [7:0] mode_sel;
    logic [7:0] mode_disp;
    logic [7:0] pol;
    logic [31:0] enc_inc;
    logic [31:0] enc_mrev;
    logic [31:0] gear_m;
    logic [31:0] gear_s;
    logic [31:0] feed;
    logic [31:0] feed_s;
    logic [31:0] num;
    logic [31:0] div;
    logic [31:0] lim_min;
    logic [31:0] lim_max;
    logic [31:0] win;
    logic [31:0] home_off;
    logic cw4;
    logic sb12;
    logic conv_err;
    logic emcy_valid;
    logic [15:0] emcy_code;
    logic cfg_reject;
    logic brake;
    logic [31:0] decel;
    logic hold_zero;
    logic [31:0] spd_set;
    logic [31:0] spd_act;
    drvsc_od_rsp_t od_rsp;
    drvsc_conv_rsp_t conv_rsp;
  } drvsc_state_t;
endpackage

// *** drvsc_core.sv ***
/*
  Drive mode selection, set-point handshake, fault stop outputs and
  position factor scaling with polarity.
  Assumes every input comes from logic on clk; none is synchronised here.
*/
`timescale 1ns/1ps
module drvsc_core
  import drvsc_pkg::*;
#(
  parameter logic [31:0] STD_INCR = drvsc_pkg::INC_BRUSHLESS
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Object dictionary access
  input wire drvsc_pkg::drvsc_od_req_t od_req,
  output drvsc_pkg::drvsc_od_rsp_t od_rsp,
  // Position conversion channel
  input wire drvsc_pkg::drvsc_conv_req_t conv_req,
  output drvsc_pkg::drvsc_conv_rsp_t conv_rsp,
  // Drive profile inputs
  input wire logic [15:0] controlword,
  input wire logic setpoint_wr,
  input wire logic [31:0] speed_actual,
  input wire logic homing_attained,
  input wire logic fault_react,
  input wire logic fault_state,
  input wire logic [31:0] profile_decel,
  input wire logic [31:0] spd_set_in,
  // Encoder configuration load
  input wire logic enc_cfg_load,
  input wire logic [31:0] enc_cfg_incr,
  // Status and drive outputs
  output logic [7:0] mode_display,
  output logic status_bit12,
  output logic [15:0] err_reg,
  output logic emcy_valid,
  output logic [15:0] emcy_code,
  output logic cfg_reject,
  output logic brake_active,
  output logic [31:0] decel_out,
  output logic hold_zero,
  output logic [31:0] spd_set_out,
  output logic [31:0] spd_act_out
);
  import drvsc_pkg::*;

  // Wide products keep the 32-bit overflow check exact
  function automatic logic [32:0] scale(input logic [31:0] v, input logic to_user,
    input logic [31:0] n, input logic [31:0] d, input logic neg);
    logic signed [63:0] p;
    logic signed [63:0] r;
    logic [31:0] m;
    logic [31:0] dv;
    m = to_user ? d : n;
    dv = to_user ? n : d;
    p = $signed({{32{v[31]}}, v}) * $signed({32'h0, m});
    r = p / $signed({32'h0, dv});
    if (neg)
    begin
      r = -r;
    end
    scale = {(r > POS_MAX) || (r < POS_MIN), r[31:0]};
  endfunction

  // Numerator maps user units to increments; zero terms count as overflow
  function automatic logic [64:0] factor(input drvsc_state_t s);
    logic [95:0] n;
    logic [95:0] d;
    n = 96'(s.enc_inc) * 96'(s.gear_m) * 96'(s.feed_s);
    d = 96'(s.feed) * 96'(s.gear_s) * 96'(s.enc_mrev);
    factor = {(n >= FAC_NUM_LIMIT) || (d[95:32] != 64'h0) || (n == 96'h0)
      || (d == 96'h0), n[31:0], d[31:0]};
  endfunction

  function automatic logic neg32_sel(input logic [7:0] pol, input int b);
    neg32_sel = pol[b];
  endfunction

  drvsc_state_t q;
  drvsc_state_t n;
  drvsc_state_t c;
  logic [32:0] cv;
  logic [64:0] fc;
  logic fw;
  logic rise;
  logic wr;
  logic [23:0] key;

  always_comb
  begin
    n = q;
    c = q;
    cv = 33'h0;
    fw = 1'b0;
    n.od_rsp = '0;
    n.conv_rsp = '0;
    n.emcy_valid = 1'b0;
    n.cfg_reject = 1'b0;
    rise = controlword[CW_NEW_SP] && !q.cw4;
    wr = od_req.valid && od_req.write;
    key = {od_req.index, od_req.sub};
    n.cw4 = controlword[CW_NEW_SP];

    // Mode start conditions
    case (q.mst)
      DRVSC_WAIT_SP:
      begin
        if (setpoint_wr)
        begin
          n.mode_disp = q.mode_sel;
          n.mst = DRVSC_RUN;
        end
      end
      DRVSC_WAIT_EDGE:
      begin
        if (rise)
        begin
          n.mode_disp = q.mode_sel;
          n.mst = DRVSC_RUN;
        end
      end
      default: n.mst = DRVSC_RUN;
    endcase

    // Factor group candidate, committed only when the factor fits
    if (enc_cfg_load)
    begin
      c.enc_inc = enc_cfg_incr;
      fw = 1'b1;
    end
    if (wr)
    begin
      case (key)
        {OD_GEAR, SUB_1}: c.gear_m = od_req.data;
        {OD_GEAR, SUB_2}: c.gear_s = od_req.data;
        {OD_FEED, SUB_1}: c.feed = od_req.data;
        {OD_FEED, SUB_2}: c.feed_s = od_req.data;
        default: c.feed = c.feed;
      endcase
    end
    fc = factor(c);

    if (od_req.valid)
    begin
      n.od_rsp.valid = 1'b1;
      case (key)
        {OD_MODE_SEL, SUB_0}:
        begin
          if (!wr)
          begin
            n.od_rsp.data = {24'h0, q.mode_sel};
          end
          else
          begin
            case (od_req.data[7:0])
              MODE_PP, MODE_PV:
              begin
                n.mode_sel = od_req.data[7:0];
                n.mst = DRVSC_WAIT_SP;
              end
              MODE_HOME:
              begin
                n.mode_sel = od_req.data[7:0];
                n.mst = DRVSC_WAIT_EDGE;
              end
              MODE_OFF, MODE_CSP:
              begin
                n.mode_sel = od_req.data[7:0];
                n.mode_disp = od_req.data[7:0];
                n.mst = DRVSC_RUN;
              end
              default:
              begin
                n.od_rsp.abort = 1'b1;
                n.od_rsp.data = ABT_RANGE;
              end
            endcase
          end
        end
        {OD_MODE_DISP, SUB_0}: n.od_rsp.data = {24'h0, q.mode_disp};
        {OD_POLARITY, SUB_0}:
        begin
          if (wr)
          begin
            n.pol = od_req.data[7:0];
          end
          n.od_rsp.data = {24'h0, q.pol};
        end
        {OD_ENC_RES, SUB_0}, {OD_GEAR, SUB_0}, {OD_FEED, SUB_0}, {OD_FACTOR, SUB_0},
        {OD_LIMIT, SUB_0}: n.od_rsp.data = OD_ENTRIES;
        {OD_ENC_RES, SUB_1}: n.od_rsp.data = q.enc_inc;
        {OD_ENC_RES, SUB_2}: n.od_rsp.data = q.enc_mrev;
        {OD_FACTOR, SUB_1}: n.od_rsp.data = q.num;
        {OD_FACTOR, SUB_2}: n.od_rsp.data = q.div;
        {OD_GEAR, SUB_1}: n.od_rsp.data = q.gear_m;
        {OD_GEAR, SUB_2}: n.od_rsp.data = q.gear_s;
        {OD_FEED, SUB_1}: n.od_rsp.data = q.feed;
        {OD_FEED, SUB_2}: n.od_rsp.data = q.feed_s;
        {OD_LIMIT, SUB_1}, {OD_LIMIT, SUB_2}, {OD_HOME_OFF, SUB_0}, {OD_WINDOW, SUB_0}:
        begin
          // Stored in increments; polarity does not apply to the window
          if (wr)
          begin
            cv = scale(od_req.data, 1'b0, q.num, q.div,
              (od_req.index != OD_WINDOW) && neg32_sel(q.pol, POL_POS_BIT));
          end
          else
          begin
            case (key)
              {OD_LIMIT, SUB_1}: cv = {1'b0, q.lim_min};
              {OD_LIMIT, SUB_2}: cv = {1'b0, q.lim_max};
              {OD_HOME_OFF, SUB_0}: cv = {1'b0, q.home_off};
              default: cv = {1'b0, q.win};
            endcase
            cv = scale(cv[31:0], 1'b1, q.num, q.div,
              (od_req.index != OD_WINDOW) && neg32_sel(q.pol, POL_POS_BIT));
          end
          if (cv[32])
          begin
            n.od_rsp.abort = 1'b1;
            n.od_rsp.data = ABT_FACTOR;
          end
          else if (!wr)
          begin
            n.od_rsp.data = cv[31:0];
          end
          else
          begin
            case (key)
              {OD_LIMIT, SUB_1}: n.lim_min = cv[31:0];
              {OD_LIMIT, SUB_2}: n.lim_max = cv[31:0];
              {OD_HOME_OFF, SUB_0}: n.home_off = cv[31:0];
              default: n.win = cv[31:0];
            endcase
          end
        end
        default:
        begin
          n.od_rsp.abort = 1'b1;
          n.od_rsp.data = ABT_NO_OBJ;
        end
      endcase
      if (wr)
      begin
        case (od_req.index)
          OD_ENC_RES, OD_FACTOR, OD_MODE_DISP:
          begin
            n.od_rsp.abort = 1'b1;
            n.od_rsp.data = ABT_READ_ONLY;
          end
          OD_GEAR, OD_FEED:
          begin
            if (od_req.sub == SUB_0)
            begin
              n.od_rsp.abort = 1'b1;
              n.od_rsp.data = ABT_READ_ONLY;
            end
            // Unknown subindices keep the not-found abort and commit nothing
            else if (od_req.sub <= SUB_2)
            begin
              fw = 1'b1;
              if (fc[64])
              begin
                n.od_rsp.abort = 1'b1;
                n.od_rsp.data = ABT_FACTOR;
              end
              n.od_rsp.data = fc[64] ? ABT_FACTOR : 32'h0;
            end
          end
          default: n.od_rsp.data = n.od_rsp.data;
        endcase
      end
    end

    if (fw && fc[64])
    begin
      n.cfg_reject = enc_cfg_load;
    end
    else if (fw)
    begin
      n.enc_inc = c.enc_inc;
      n.gear_m = c.gear_m;
      n.gear_s = c.gear_s;
      n.feed = c.feed;
      n.feed_s = c.feed_s;
      n.num = fc[63:32];
      n.div = fc[31:0];
      if (q.conv_err)
      begin
        n.conv_err = 1'b0;
        n.emcy_valid = 1'b1;
        n.emcy_code = EMCY_CLEAR;
      end
    end

    // Conversion channel; an overflow here outranks a same-cycle clear
    if (conv_req.valid)
    begin
      cv = scale(conv_req.value, conv_req.to_user, q.num, q.div,
        neg32_sel(q.pol, POL_POS_BIT));
      n.conv_rsp = {1'b1, cv};
      if (cv[32])
      begin
        n.conv_err = 1'b1;
        n.emcy_valid = 1'b1;
        n.emcy_code = EMCY_CONV;
      end
    end

    // Status bit 12 follows the running mode
    case (q.mode_disp)
      MODE_PP:
      begin
        if (!controlword[CW_NEW_SP])
        begin
          n.sb12 = 1'b0;
        end
        else if (rise)
        begin
          n.sb12 = 1'b1;
        end
      end
      MODE_PV: n.sb12 = (speed_actual == 32'h0);
      MODE_HOME: n.sb12 = homing_attained;
      default: n.sb12 = 1'b0;
    endcase

    // Fault stopping and speed polarity
    n.brake = fault_react;
    n.decel = fault_react ? profile_decel : 32'h0;
    n.hold_zero = fault_state;
    if (fault_state)
    begin
      n.spd_set = 32'h0;
    end
    else
    begin
      n.spd_set = neg32_sel(q.pol, POL_SPD_BIT) ? -spd_set_in : spd_set_in;
    end
    n.spd_act = neg32_sel(q.pol, POL_SPD_BIT) ? -speed_actual : speed_actual;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      q <= '0;
      q.mst <= DRVSC_RUN;
      q.mode_sel <= RST_MODE;
      q.mode_disp <= RST_MODE;
      q.pol <= RST_POL;
      q.enc_inc <= STD_INCR;
      q.enc_mrev <= RST_ONE;
      q.gear_m <= RST_ONE;
      q.gear_s <= RST_ONE;
      q.feed <= STD_INCR;
      q.feed_s <= RST_ONE;
      q.num <= RST_ONE;
      q.div <= RST_ONE;
      q.lim_min <= RST_LIM_MIN;
      q.lim_max <= RST_LIM_MAX;
      q.win <= RST_WINDOW;
      q.home_off <= RST_HOME_OFF;
    end
    else
    begin
      q <= n;
    end
  end

  assign od_rsp = q.od_rsp;
  assign conv_rsp = q.conv_rsp;
  assign mode_display = q.mode_disp;
  assign status_bit12 = q.sb12;
  assign err_reg = {4'h0, q.conv_err, 11'h0};
  assign emcy_valid = q.emcy_valid;
  assign emcy_code = q.emcy_code;
  assign cfg_reject = q.cfg_reject;
  assign brake_active = q.brake;
  assign decel_out = q.decel;
  assign hold_zero = q.hold_zero;
  assign spd_set_out = q.spd_set;
  assign spd_act_out = q.spd_act;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_pp_ack_set: assert property ((mode_display == MODE_PP) && rise |=> status_bit12)
    else $error("ack not raised");
  a_pp_ack_clr: assert property ((mode_display == MODE_PP) && !controlword[CW_NEW_SP]
    |=> !status_bit12)
    else $error("ack not cleared");
  a_pv_speed_zero: assert property ((mode_display == MODE_PV)
    |=> status_bit12 == ($past(speed_actual) == 32'h0))
    else $error("speed zero flag wrong");
  a_fault_brake: assert property (fault_react
    |=> brake_active && (decel_out == $past(profile_decel)))
    else $error("brake ramp missing");
  a_fault_hold: assert property (fault_state |=> hold_zero && (spd_set_out == 32'h0))
    else $error("speed not held at zero");
  a_sp_wait_hold: assert property ((q.mst == DRVSC_WAIT_SP) && !setpoint_wr && !wr
    |=> $stable(mode_display))
    else $error("mode started early");
  a_home_edge: assert property ((q.mst == DRVSC_WAIT_EDGE) && rise && !wr
    |=> mode_display == MODE_HOME)
    else $error("homing not started on edge");
  a_factor_ro: assert property (wr && (od_req.index == OD_FACTOR)
    |=> od_rsp.valid && od_rsp.abort)
    else $error("factor write accepted");
  a_conv_emcy: assert property (conv_rsp.valid && conv_rsp.ovf
    |-> emcy_valid && (emcy_code == EMCY_CONV) && err_reg[ERR_CONV_BIT])
    else $error("overflow not reported");
  a_conv_clear: assert property ($fell(err_reg[ERR_CONV_BIT])
    |-> emcy_valid && (emcy_code == EMCY_CLEAR))
    else $error("clear not reported");
  a_pol_speed: assert property (!fault_state ##1 1 |-> spd_act_out ==
    ($past(q.pol[POL_SPD_BIT]) ? -$past(speed_actual) : $past(speed_actual)))
    else $error("speed polarity wrong");

  c_pp_handshake: cover property (rise ##1 status_bit12 ##[1:20] !status_bit12);
  c_mode_switch: cover property ((q.mst == DRVSC_WAIT_SP) ##[1:20] (q.mst == DRVSC_RUN));
  c_factor_abort: cover property (od_rsp.valid && od_rsp.abort && (od_rsp.data == ABT_FACTOR));
  c_conv_ovf: cover property (conv_rsp.valid && conv_rsp.ovf);
endmodule

// *** drvsc_host.sv ***
/*
  Host master model: object access and the controlword strobe.
  Assumes the device answers each object request one cycle later.
*/
`timescale 1ns/1ps
module drvsc_host
  import drvsc_pkg::*;
(
  // Clock
  input wire logic clk,
  // Object access
  output drvsc_pkg::drvsc_od_req_t od_req,
  input wire drvsc_pkg::drvsc_od_rsp_t od_rsp,
  // Controlword
  output logic [15:0] controlword
);
  initial
  begin
    od_req = '0;
    controlword = 16'h0000;
  end
  // Callers set factor terms first and may push the numerator out of range to provoke the factor abort
  task automatic acc(input logic w, input logic [15:0] i, input logic [7:0] s,
    input logic [31:0] d, output drvsc_od_rsp_t r);
    @(posedge clk);
    #1;
    od_req = '{valid: 1'b1, write: w, index: i, sub: s, data: d};
    @(posedge clk);
    #1;
    r = od_rsp;
    // Released fields show garbage, never the last request
    od_req = '{valid: 1'b0, write: ~w, index: ~i, sub: ~s, data: ~d};
  endtask
  task automatic new_sp(input logic v);
    @(posedge clk);
    #1;
    controlword[CW_NEW_SP] = v;
  endtask
endmodule

// *** tb_top.sv ***
/*
  Self-checking bench for drvsc_core.
  Assumes the host model drives object access and the controlword.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_total++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_top;
  import drvsc_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  drvsc_od_req_t od_req;
  drvsc_od_rsp_t od_rsp, r;
  drvsc_conv_req_t cq = '0;
  drvsc_conv_rsp_t cs;
  logic [15:0] cw, err_reg, emcy_code;
  logic sp_wr = 1'b0, h_att = 1'b0, f_re = 1'b0, f_st = 1'b0, ld = 1'b0;
  logic [31:0] spd = '0, dec = '0, sps = '0, incr = '0;
  logic [7:0] disp;
  logic sb12, emcy_valid, rej, brk, hz;
  logic [31:0] dec_o, sps_o, spa_o;
  int err_total = 0;
  int tests_run = 0;
  always #10 clk = ~clk;
  drvsc_host host (.clk(clk), .od_req(od_req), .od_rsp(od_rsp), .controlword(cw));
  drvsc_core dut (.clk(clk), .rst_b(rst_b), .od_req(od_req), .od_rsp(od_rsp),
    .conv_req(cq), .conv_rsp(cs), .controlword(cw), .setpoint_wr(sp_wr),
    .speed_actual(spd), .homing_attained(h_att), .fault_react(f_re),
    .fault_state(f_st), .profile_decel(dec), .spd_set_in(sps),
    .enc_cfg_load(ld), .enc_cfg_incr(incr), .mode_display(disp),
    .status_bit12(sb12), .err_reg(err_reg), .emcy_valid(emcy_valid),
    .emcy_code(emcy_code), .cfg_reject(rej), .brake_active(brk),
    .decel_out(dec_o), .hold_zero(hz), .spd_set_out(sps_o), .spd_act_out(spa_o));
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic rd(input logic [15:0] i, input logic [7:0] s, input logic [31:0] e);
    host.acc(1'b0, i, s, 32'h0000_0000, r);
    `CHK({r.valid, r.abort}, 2'b10)
    `CHK(r.data, e)
  endtask
  task automatic wr(input logic [15:0] i, input logic [7:0] s, input logic [31:0] d,
    input logic ab, input logic [31:0] e);
    host.acc(1'b1, i, s, d, r);
    `CHK({r.valid, r.abort}, {1'b1, ab})
    `CHK(r.data, e)
  endtask
  // Checks the answer and, on overflow, the emergency of the same cycle
  task automatic cv(input logic tu, input logic [31:0] v, input logic [31:0] e,
    input logic ov);
    @(posedge clk);
    #1;
    cq = '{valid: 1'b1, to_user: tu, value: v};
    @(posedge clk);
    #1;
    cq = '{valid: 1'b0, to_user: ~tu, value: ~v};
    `CHK({cs.valid, cs.ovf}, {1'b1, ov})
    if (ov)
    begin
      `CHK({emcy_valid, emcy_code}, {1'b1, 16'hFF01})
    end
    else
    begin
      `CHK(cs.value, e)
    end
  endtask
  task automatic load(input logic [31:0] v, input logic e);
    @(posedge clk);
    #1;
    ld = 1'b1;
    incr = v;
    @(posedge clk);
    #1;
    ld = 1'b0;
    incr = ~v;
    `CHK(rej, e)
  endtask
  task automatic sp_pulse();
    sp_wr = 1'b1;
    cyc(1);
    sp_wr = 1'b0;
    cyc(2);
  endtask
  initial
  begin
    cyc(5);
    rst_b = 1'b1;
    rd(OD_MODE_SEL, SUB_0, 32'h01);
    rd(OD_MODE_DISP, SUB_0, 32'h01);
    rd(OD_POLARITY, SUB_0, 32'h00);
    rd(OD_FACTOR, SUB_1, 32'h01);
    rd(OD_FACTOR, SUB_2, 32'h01);
    rd(OD_FEED, SUB_1, 32'hBB8);
    rd(OD_ENC_RES, SUB_1, 32'hBB8);
    wr(OD_FACTOR, SUB_1, 32'h5, 1'b1, ABT_READ_ONLY);
    wr(OD_ENC_RES, SUB_1, 32'h5, 1'b1, ABT_READ_ONLY);
    wr(OD_MODE_DISP, SUB_0, 32'h3, 1'b1, ABT_READ_ONLY);
    wr(OD_MODE_SEL, SUB_0, 32'h2, 1'b1, ABT_RANGE);
    wr(16'h1234, SUB_0, 32'h0, 1'b1, ABT_NO_OBJ);
    // Gear 5:1 gives numerator 15000 over divisor 3000
    wr(OD_GEAR, SUB_1, 32'd5, 1'b0, 32'h0);
    rd(OD_FACTOR, SUB_1, 32'd15000);
    rd(OD_FACTOR, SUB_2, 32'd3000);
    cv(1'b1, 32'd300, 32'd60, 1'b0);
    cv(1'b0, 32'd60, 32'd300, 1'b0);
    rd(OD_WINDOW, SUB_0, 32'd6);
    wr(OD_GEAR, SUB_1, 32'd700000, 1'b1, ABT_FACTOR);
    rd(OD_GEAR, SUB_1, 32'd5);
    cv(1'b0, 32'h7FFF_FFFF, 32'h0, 1'b1);
    `CHK(err_reg, 16'h0800)
    wr(OD_GEAR, SUB_1, 32'd1, 1'b0, 32'h0);
    `CHK({emcy_valid, err_reg}, 17'h1_0000)
    cyc(1);
    `CHK({err_reg, emcy_code}, 32'h0)
    wr(OD_POLARITY, SUB_0, 32'hC0, 1'b0, 32'h0);
    cv(1'b1, 32'd300, 32'hFFFF_FED4, 1'b0);
    rd(OD_LIMIT, SUB_1, 32'h6B49_D200);
    rd(OD_LIMIT, SUB_2, 32'h94B6_2E00);
    spd = 32'd100;
    cyc(2);
    `CHK(spa_o, 32'hFFFF_FF9C)
    // A polarity write answers with the value it replaces
    wr(OD_POLARITY, SUB_0, 32'h00, 1'b0, 32'h0000_00C0);
    wr(OD_MODE_SEL, SUB_0, 32'h03, 1'b0, 32'h0);
    cyc(3);
    `CHK(disp, 8'h01)
    sp_pulse();
    `CHK(disp, 8'h03)
    `CHK(sb12, 1'b0)
    spd = 32'd0;
    cyc(2);
    `CHK(sb12, 1'b1)
    wr(OD_MODE_SEL, SUB_0, 32'h06, 1'b0, 32'h0);
    sp_pulse();
    `CHK(disp, 8'h03)
    host.new_sp(1'b1);
    cyc(2);
    `CHK(disp, 8'h06)
    h_att = 1'b1;
    cyc(2);
    `CHK(sb12, 1'b1)
    h_att = 1'b0;
    host.new_sp(1'b0);
    wr(OD_MODE_SEL, SUB_0, 32'h01, 1'b0, 32'h0);
    sp_pulse();
    `CHK({disp, sb12}, 9'h002)
    host.new_sp(1'b1);
    cyc(2);
    `CHK(sb12, 1'b1)
    host.new_sp(1'b0);
    cyc(2);
    `CHK(sb12, 1'b0)
    wr(OD_MODE_SEL, SUB_0, 32'h08, 1'b0, 32'h0);
    cyc(2);
    `CHK(disp, 8'h08)
    wr(OD_MODE_SEL, SUB_0, 32'h00, 1'b0, 32'h0);
    cyc(2);
    `CHK(disp, 8'h00)
    f_re = 1'b1;
    dec = 32'd30000;
    sps = 32'h10;
    cyc(2);
    `CHK({brk, dec_o}, {1'b1, 32'd30000})
    f_re = 1'b0;
    f_st = 1'b1;
    cyc(2);
    `CHK({hz, sps_o}, {1'b1, 32'h0})
    f_st = 1'b0;
    cyc(2);
    `CHK({brk, hz, sps_o}, {2'b00, 32'h10})
    load(32'h1000, 1'b0);
    rd(OD_ENC_RES, SUB_1, 32'h1000);
    rd(OD_FACTOR, SUB_1, 32'h1000);
    load(32'h8000_0000, 1'b1);
    rd(OD_ENC_RES, SUB_1, 32'h1000);
    give_verdict();
  end
  initial
  begin
    #100000;
    err_total++;
    give_verdict();
  end
endmodule
